/* File: design/eem_pkg.sv */
// Contract
// - EEPROM appears at external addresses 0000h..07FFh when the control map bit is set.
// - A mapped external read returns the stored EEPROM byte at that address.
// - Writes go to column latches first, then programming moves them into one row.
// - One to 128 bytes may be latched per programming session; a page is 128 bytes.
// - Each latched byte carries a flag; only flagged bytes are programmed.
// - All latch flags are cleared once row programming completes.
// - Address bits 10:7 select the row, bits 6:0 the byte in it.
// - A mapped external write stores one byte into the addressed column latch.
// - If latch writes span pages, the first page is kept and others discarded.
// - Any instruction between the 5xh and Axh writes aborts the launch; here a repeated 5xh write re-arms it instead.
// - Launch sets the busy flag and blocks EEPROM reads until programming ends.
// - Hardware clears the busy flag when programming is done.
// - Map bit set routes external moves to EEPROM, clear routes them to expanded RAM.
// - The busy flag is read-only; software writes neither set nor clear it.
// - Launch code sits in control bits 7:4, map bit at 1, busy flag at 0.
package eem_pkg;

  // Register offsets on the APB side.
  localparam logic [7:0]  CTRL_OFS     = 8'h00;
  localparam logic [7:0]  STAT_OFS     = 8'h04;

  // Control register fields.
  localparam int          CODE_LSB     = 4;
  localparam int          MAP_BIT      = 1;
  localparam int          BUSY_BIT     = 0;
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;

  // Status register fields.
  localparam int          ST_PAGE_LSB  = 0;
  localparam int          ST_VLD_BIT   = 4;
  localparam int          ST_ABORT_BIT = 5;

  // Launch sequence codes, upper nibble only.
  localparam logic [3:0]  CODE_ARM     = 4'h5;
  localparam logic [3:0]  CODE_FIRE    = 4'ha;

  // Geometry.
  localparam int          EE_BYTES     = 2048;
  localparam int          PAGE_BYTES   = 128;
  localparam logic [15:0] EE_LAST      = 16'h07ff;
  localparam logic [7:0]  BUSY_RDATA   = 8'hff;

  // Row programming time and its cycle count at 50 MHz.
  localparam int          PROG_TIME_US = 10;
  localparam int          CLK_MHZ      = 50;
  localparam int          PROG_CYCLES  = PROG_TIME_US * CLK_MHZ;
  localparam int          CNT_W        = 16;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } eem_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } eem_apb_rsp_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } eem_xreq_t;

  typedef struct packed {
    logic        ack;
    logic [7:0]  rdata;
    logic        busy_err;
  } eem_xrsp_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  addr;
    logic [7:0]  wdata;
  } eem_ram_req_t;

  typedef struct packed {
    logic [EE_BYTES-1:0][7:0]   mem;
    logic [PAGE_BYTES-1:0][7:0] lat;
    logic [PAGE_BYTES-1:0]      flg;
    logic [3:0]                 page;
    logic                       page_vld;
    logic                       map;
    logic [3:0]                 code;
    logic                       armed;
    logic                       busy;
    logic                       aborted;
    logic [CNT_W-1:0]           cnt;
    logic [31:0]                prdata;
    logic                       pslverr;
    logic                       xack;
    logic [7:0]                 xrdata;
    logic                       xerr;
  } eem_state_t;

endpackage : eem_pkg

/* File: design/eem_access.sv */
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module eem_access #(
  parameter int PROG_CYCLES_P = eem_pkg::PROG_CYCLES
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire eem_pkg::eem_apb_req_t apb_req,
  output var  eem_pkg::eem_apb_rsp_t apb_rsp,
  input  wire eem_pkg::eem_xreq_t    xreq,
  output var  eem_pkg::eem_xrsp_t    xrsp,
  input  wire logic                  instr_step,
  output var  eem_pkg::eem_ram_req_t ram_req,
  input  wire logic [7:0]            ram_rdata,
  output logic                       program_in_progress_flag
);
  import eem_pkg::*;

  eem_state_t s_reg;
  eem_state_t s_next;

  // Decoded strobes shared by the next-state logic and the checks.
  logic apb_setup;
  logic apb_wr_ctrl;
  logic apb_access;
  logic x_in_ee;
  logic lat_ok;
  logic fire;

  function automatic logic in_ee_space(input logic [15:0] a);
    in_ee_space = (a <= EE_LAST);
  endfunction : in_ee_space

  // Strobe decode; APB answers without wait states.
  always_comb begin
    apb_setup   = apb_req.psel && !apb_req.penable;
    apb_access  = apb_req.psel && apb_req.penable;
    apb_wr_ctrl = apb_access && apb_req.pwrite && (apb_req.paddr == CTRL_OFS);
    x_in_ee     = xreq.valid && s_reg.map && in_ee_space(xreq.addr);
    // A latch write is kept only while idle and, once a page is held, only on that page.
    lat_ok      = x_in_ee && xreq.write && !s_reg.busy
                  && (!s_reg.page_vld || (s_reg.page == xreq.addr[10:7]));
    fire        = apb_wr_ctrl && (apb_req.pwdata[7:CODE_LSB] == CODE_FIRE)
                  && s_reg.armed && !s_reg.busy;
  end

  // Next state of the whole block.
  always_comb begin
    s_next      = s_reg;
    s_next.xack = 1'b0;
    s_next.xerr = 1'b0;

    // Read data is captured in the setup phase so prdata comes from a flop.
    if (apb_setup) begin
      s_next.pslverr = 1'b0;
      s_next.prdata  = 32'h0000_0000;
      if (apb_req.paddr == CTRL_OFS) begin
        s_next.prdata[7:CODE_LSB] = s_reg.code;
        s_next.prdata[MAP_BIT]    = s_reg.map;
        s_next.prdata[BUSY_BIT]   = s_reg.busy;
      end else if (apb_req.paddr == STAT_OFS) begin
        s_next.prdata[ST_PAGE_LSB +: 4] = s_reg.page;
        s_next.prdata[ST_VLD_BIT]       = s_reg.page_vld;
        s_next.prdata[ST_ABORT_BIT]     = s_reg.aborted;
      end else begin
        s_next.pslverr = 1'b1;
      end
    end

    // An armed launch dies on any instruction other than the firing write or a repeated arming write.
    if (s_reg.armed && !fire) begin
      if (instr_step || xreq.valid || (apb_access && !apb_wr_ctrl)) begin
        s_next.armed   = 1'b0;
        s_next.aborted = 1'b1;
      end
    end

    // Control writes; the busy bit in the write data is ignored.
    if (apb_wr_ctrl) begin
      s_next.map  = apb_req.pwdata[MAP_BIT];
      s_next.code = apb_req.pwdata[7:CODE_LSB];
      if (fire) begin
        s_next.busy    = 1'b1;
        s_next.armed   = 1'b0;
        s_next.aborted = 1'b0;
        s_next.cnt     = CNT_W'(PROG_CYCLES_P - 1);
      end else if (apb_req.pwdata[7:CODE_LSB] == CODE_ARM) begin
        s_next.armed   = !s_reg.busy;
      end else begin
        s_next.aborted = s_reg.armed || s_reg.aborted;
        s_next.armed   = 1'b0;
      end
    end

    // External data moves: EEPROM latches and array, or expanded RAM.
    if (xreq.valid) begin
      s_next.xack = 1'b1;
      if (!s_reg.map) begin
        s_next.xrdata = ram_rdata;
      end else if (!in_ee_space(xreq.addr)) begin
        s_next.xrdata = 8'h00;
      end else if (xreq.write) begin
        if (lat_ok) begin
          s_next.lat[xreq.addr[6:0]] = xreq.wdata;
          s_next.flg[xreq.addr[6:0]] = 1'b1;
          s_next.page                = xreq.addr[10:7];
          s_next.page_vld            = 1'b1;
        end
      end else if (s_reg.busy) begin
        s_next.xrdata = BUSY_RDATA;
        s_next.xerr   = 1'b1;
      end else begin
        s_next.xrdata = s_reg.mem[xreq.addr[10:0]];
      end
    end

    // Row programming: only flagged bytes land in the row, then flags clear.
    if (s_reg.busy) begin
      if (s_reg.cnt == '0) begin
        for (int i = 0; i < PAGE_BYTES; i++) begin
          if (s_reg.flg[i]) begin
            s_next.mem[{s_reg.page, 7'(i)}] = s_reg.lat[i];
          end
        end
        s_next.flg      = '0;
        s_next.page_vld = 1'b0;
        s_next.busy     = 1'b0;
      end else begin
        s_next.cnt = s_reg.cnt - CNT_W'(1);
      end
    end
  end

  // The single state register. Array contents clear on reset as well.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs; the RAM path is combinational so the RAM sees the move at once.
  always_comb begin
    apb_rsp.pready           = 1'b1;
    apb_rsp.prdata           = s_reg.prdata;
    apb_rsp.pslverr          = s_reg.pslverr && apb_access;
    xrsp.ack                 = s_reg.xack;
    xrsp.rdata               = s_reg.xrdata;
    xrsp.busy_err            = s_reg.xerr;
    ram_req.valid            = xreq.valid && !s_reg.map;
    ram_req.write            = xreq.write;
    ram_req.addr             = xreq.addr[7:0];
    ram_req.wdata            = xreq.wdata;
    program_in_progress_flag = s_reg.busy;
  end

  // Checks.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [7:0] exp_rd;
  assign exp_rd = s_reg.mem[xreq.addr[10:0]];

  property p_busy_ro;
    (apb_wr_ctrl && !fire && !s_reg.busy) |=> !s_reg.busy;
  endproperty
  a_busy_ro: assert property (p_busy_ro) else $error("busy flag set by software write");

  property p_launch;
    (apb_wr_ctrl && apb_req.pwdata[7:CODE_LSB] == CODE_ARM && !s_reg.busy)
      ##1 (!instr_step && !xreq.valid && !apb_access)[*2]
      ##1 (apb_wr_ctrl && apb_req.pwdata[7:CODE_LSB] == CODE_FIRE)
      |=> program_in_progress_flag;
  endproperty
  a_launch: assert property (p_launch) else $error("launch sequence did not start programming");

  property p_abort;
    (s_reg.armed && !fire && !apb_wr_ctrl && (instr_step || xreq.valid))
      |=> !s_reg.armed && s_reg.aborted && !program_in_progress_flag;
  endproperty
  a_abort: assert property (p_abort) else $error("interrupted launch still programmed");

  property p_read_blocked;
    (x_in_ee && !xreq.write && s_reg.busy) |=> xrsp.busy_err && xrsp.rdata == BUSY_RDATA;
  endproperty
  a_read_blocked: assert property (p_read_blocked) else $error("EEPROM read served while busy");

  property p_done;
    (s_reg.busy && s_reg.cnt == '0) |=> !program_in_progress_flag && s_reg.flg == '0 && !s_reg.page_vld;
  endproperty
  a_done: assert property (p_done) else $error("programming end left busy or flags");

  property p_prog_len;
    $rose(s_reg.busy) |-> s_reg.cnt == CNT_W'(PROG_CYCLES_P - 1) ##1 s_reg.busy;
  endproperty
  a_prog_len: assert property (p_prog_len) else $error("programming time wrong");

  property p_latch;
    lat_ok |=> s_reg.flg[$past(xreq.addr[6:0])] && s_reg.lat[$past(xreq.addr[6:0])] == $past(xreq.wdata);
  endproperty
  a_latch: assert property (p_latch) else $error("column latch write lost");

  property p_first_page;
    (x_in_ee && xreq.write && s_reg.page_vld && s_reg.page != xreq.addr[10:7] && !s_reg.busy)
      |=> $stable(s_reg.page) && $stable(s_reg.lat);
  endproperty
  a_first_page: assert property (p_first_page) else $error("foreign page write not discarded");

  property p_commit;
    (s_reg.busy && s_reg.cnt == '0 && s_reg.flg[0])
      |=> s_reg.mem[{$past(s_reg.page), 7'h00}] == $past(s_reg.lat[0]);
  endproperty
  a_commit: assert property (p_commit) else $error("flagged byte not programmed into row");

  property p_read;
    (x_in_ee && !xreq.write && !s_reg.busy) |=> xrsp.ack && xrsp.rdata == $past(exp_rd);
  endproperty
  a_read: assert property (p_read) else $error("EEPROM read data wrong");

  property p_route;
    (xreq.valid && !s_reg.map) |-> ram_req.valid ##1 (xrsp.ack && !xrsp.busy_err);
  endproperty
  a_route: assert property (p_route) else $error("unmapped move not sent to RAM");

  property p_oob;
    (xreq.valid && s_reg.map && !in_ee_space(xreq.addr) && !xreq.write) |=> xrsp.rdata == 8'h00;
  endproperty
  a_oob: assert property (p_oob) else $error("read above EEPROM space not zero");

  // Control readback shows code, map bit and busy flag in their fields.
  property p_ctrl_rd;
    (apb_setup && apb_req.paddr == CTRL_OFS)
      |=> apb_rsp.prdata == {24'h0, $past(s_reg.code), 2'h0, $past(s_reg.map), $past(s_reg.busy)};
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback wrong");

  // Status readback shows the held page, its valid bit and the abort bit.
  property p_stat_rd;
    (apb_setup && apb_req.paddr == STAT_OFS)
      |=> apb_rsp.prdata == {26'h0, $past(s_reg.aborted), $past(s_reg.page_vld), $past(s_reg.page)};
  endproperty
  a_stat_rd: assert property (p_stat_rd) else $error("status readback wrong");

  // An unmapped register offset reads zero and flags an error.
  property p_bad_ofs;
    (apb_setup && apb_req.paddr != CTRL_OFS && apb_req.paddr != STAT_OFS)
      |=> apb_rsp.prdata == 32'h0 && s_reg.pslverr;
  endproperty
  a_bad_ofs: assert property (p_bad_ofs) else $error("unmapped offset not refused");

  // The map bit follows every control write.
  property p_map_wr;
    apb_wr_ctrl |=> s_reg.map == $past(apb_req.pwdata[MAP_BIT]);
  endproperty
  a_map_wr: assert property (p_map_wr) else $error("map bit not written");

  // Nothing but the end of the count may clear the busy flag.
  property p_busy_hold;
    (s_reg.busy && s_reg.cnt != '0) |=> s_reg.busy;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy flag cleared early");

  // Latch writes are refused while a row is being programmed.
  property p_busy_lat;
    (x_in_ee && xreq.write && s_reg.busy && s_reg.cnt != '0) |=> $stable(s_reg.flg) && $stable(s_reg.lat);
  endproperty
  a_busy_lat: assert property (p_busy_lat) else $error("latch written while busy");

  // A write above the EEPROM space must not touch the latches.
  property p_oob_wr;
    (xreq.valid && s_reg.map && !in_ee_space(xreq.addr) && xreq.write && !s_reg.busy)
      |=> $stable(s_reg.lat) && $stable(s_reg.page_vld);
  endproperty
  a_oob_wr: assert property (p_oob_wr) else $error("write above EEPROM space latched");

  // Every move is acknowledged exactly one cycle later, and nothing else is.
  property p_ack;
    1'b1 |=> xrsp.ack == $past(xreq.valid);
  endproperty
  a_ack: assert property (p_ack) else $error("move acknowledge misplaced");

  // Read data holds between moves so a slow reader still sees it.
  property p_rd_hold;
    !xreq.valid |=> $stable(xrsp.rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data changed without a move");

  // A firing code without a prior arm must not start programming.
  property p_no_fire;
    (apb_wr_ctrl && apb_req.pwdata[7:CODE_LSB] == CODE_FIRE && !s_reg.armed && !s_reg.busy) |=> !s_reg.busy;
  endproperty
  a_no_fire: assert property (p_no_fire) else $error("unarmed launch programmed");

  // The arming code arms the launch while idle.
  property p_arm;
    (apb_wr_ctrl && apb_req.pwdata[7:CODE_LSB] == CODE_ARM && !s_reg.busy) |=> s_reg.armed;
  endproperty
  a_arm: assert property (p_arm) else $error("arming code ignored");

  // The held page never moves while it is valid.
  property p_page_hold;
    s_reg.page_vld |=> $stable(s_reg.page);
  endproperty
  a_page_hold: assert property (p_page_hold) else $error("held page changed");

  // The array changes only at the end of a programming run.
  property p_mem_still;
    !(s_reg.busy && s_reg.cnt == '0) |=> $stable(s_reg.mem);
  endproperty
  a_mem_still: assert property (p_mem_still) else $error("array changed outside programming");

  // The last byte of the page lands in its row when flagged.
  property p_commit_last;
    (s_reg.busy && s_reg.cnt == '0 && s_reg.flg[PAGE_BYTES-1])
      |=> s_reg.mem[{$past(s_reg.page), 7'h7f}] == $past(s_reg.lat[PAGE_BYTES-1]);
  endproperty
  a_commit_last: assert property (p_commit_last) else $error("last flagged byte not programmed");

  // An unflagged byte keeps its old array contents.
  property p_unflagged;
    (s_reg.busy && s_reg.cnt == '0 && !s_reg.flg[1]) |=> $stable(s_reg.mem[{s_reg.page, 7'h01}]);
  endproperty
  a_unflagged: assert property (p_unflagged) else $error("unflagged byte programmed");

  // A successful launch consumes the arm and clears the abort bit.
  property p_fire_clr;
    fire |=> !s_reg.armed && !s_reg.aborted;
  endproperty
  a_fire_clr: assert property (p_fire_clr) else $error("launch left arm or abort set");

  // A read while idle is never refused.
  property p_rd_ok;
    (x_in_ee && !xreq.write && !s_reg.busy) |=> !xrsp.busy_err;
  endproperty
  a_rd_ok: assert property (p_rd_ok) else $error("idle EEPROM read refused");

  // With the map bit clear, read data comes from the expanded RAM.
  property p_ram_rd;
    (xreq.valid && !s_reg.map && !xreq.write) |=> xrsp.rdata == $past(ram_rdata);
  endproperty
  a_ram_rd: assert property (p_ram_rd) else $error("expanded RAM data not returned");

  c_launch: cover property ($rose(program_in_progress_flag));
  c_done:   cover property ($fell(program_in_progress_flag));
  c_abort:  cover property ($rose(s_reg.aborted));
  c_busyrd: cover property (x_in_ee && !xreq.write && s_reg.busy);
  c_latch:  cover property (lat_ok);

endmodule : eem_access
`default_nettype wire

/* File: test/eem_ram_model.sv */
`timescale 1ns/1ns
`default_nettype none
module eem_ram_model (
  input  wire logic                  pclk,
  input  wire eem_pkg::eem_ram_req_t ram_req,
  output logic [7:0]                 ram_rdata
);
  import eem_pkg::*;
  logic [7:0] mem [256];
  logic [7:0] junk;

  // Outside a read the lines carry a pattern that changes every cycle, so a stale byte never passes.
  always_comb ram_rdata = (ram_req.valid && !ram_req.write) ? mem[ram_req.addr] : junk;

  // Writes land at the clock edge, as in a synchronous RAM.
  always_ff @(posedge pclk) begin
    junk <= (junk === 8'hxx) ? 8'h5a : ~junk + 8'h01;
    if (ram_req.valid && ram_req.write) begin
      mem[ram_req.addr] <= ram_req.wdata;
    end
  end
endmodule : eem_ram_model
`default_nettype wire

/* File: test/eem_access_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module eem_access_tb;
  import eem_pkg::*;
  localparam int PROG_N = 8;
  logic         pclk;
  logic         presetn;
  eem_apb_req_t apb_req;
  eem_apb_rsp_t apb_rsp;
  eem_xreq_t    xreq;
  eem_xrsp_t    xrsp;
  logic         instr_step;
  eem_ram_req_t ram_req;
  logic [7:0]   ram_rdata;
  logic         prog_flag;
  int           num_errors;
  int           tests_run;
  logic [32:0]  apb_q[$];
  logic [9:0]   x_q[$];
  logic [7:0]   d0, d1, d2;
  logic [32:0]  ae;
  logic [9:0]   xe;

  eem_access #(.PROG_CYCLES_P(PROG_N)) i_dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .xreq(xreq), .xrsp(xrsp), .instr_step(instr_step), .ram_req(ram_req),
    .ram_rdata(ram_rdata), .program_in_progress_flag(prog_flag));
  eem_ram_model i_ram (.pclk(pclk), .ram_req(ram_req), .ram_rdata(ram_rdata));

  // Bus clock, 20 ns period.
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic stop_test();
    if (num_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One register transfer; the request is held until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    @(posedge pclk);
    while (apb_rsp.pready !== 1'b1) @(posedge pclk);
    apb_req <= '0;
    @(posedge pclk);
  endtask : apb

  task automatic apb_rd(input logic [7:0] a, input logic [32:0] e);
    apb_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : apb_rd

  // One external data move; the idle cycle after it keeps valid from being assigned twice in a step.
  task automatic xmove(input logic w, input logic [15:0] a, input logic [7:0] d, input logic [9:0] e);
    x_q.push_back(e);
    xreq <= '{valid: 1'b1, write: w, addr: a, wdata: d};
    @(posedge pclk);
    xreq.valid <= 1'b0;
    @(posedge pclk);
  endtask : xmove

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    xmove(1'b1, a, d, 10'h0);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic be);
    xmove(1'b0, a, 8'h00, {1'b1, be, e});
  endtask : rd

  // Both launch codes keep the map bit set so reads can follow at once.
  task automatic launch();
    apb(1'b1, CTRL_OFS, 32'h52);
    apb(1'b1, CTRL_OFS, 32'ha2);
  endtask : launch

  task automatic wait_idle();
    int n;
    n = 0;
    while (prog_flag !== 1'b0 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    check({32'h0, prog_flag}, 33'h0);
  endtask : wait_idle

  // Results are matched against the oldest outstanding note.
  always @(posedge pclk) begin
    if (presetn && xrsp.ack === 1'b1) begin
      xe = x_q.pop_front();
      if (xe[9]) check({24'h0, xrsp.busy_err, xrsp.rdata}, {24'h0, xe[8:0]});
    end
    if (apb_req.psel && apb_req.penable && !apb_req.pwrite && apb_rsp.pready === 1'b1) begin
      ae = apb_q.pop_front();
      check({apb_rsp.pslverr, apb_rsp.prdata}, ae);
    end
  end

  // Main sequence.
  initial begin
    num_errors = 0;
    tests_run = 0;
    presetn = 1'b0;
    apb_req = '0;
    xreq = '0;
    instr_step = 1'b0;
    void'($urandom(93876));
    d0 = 8'($urandom()) | 8'h01;
    d1 = 8'($urandom()) | 8'h01;
    d2 = 8'($urandom()) | 8'h01;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb_rd(CTRL_OFS, 33'h0);
    wr(16'h0010, d2);
    rd(16'h0010, d2, 1'b0);
    apb(1'b1, CTRL_OFS, 32'h03);
    apb_rd(CTRL_OFS, 33'h002);
    apb_rd(8'h08, {1'b1, 32'h0});
    rd(16'h0105, 8'h00, 1'b0);
    rd(16'h0800, 8'h00, 1'b0);
    wr(16'h0880, d0);
    wr(16'h0100, d0);
    wr(16'h017f, d1);
    wr(16'h0185, d2);
    apb_rd(STAT_OFS, 33'h012);
    launch();
    rd(16'h0100, BUSY_RDATA, 1'b1);
    check({32'h0, prog_flag}, 33'h1);
    wr(16'h0102, d1);
    wait_idle();
    rd(16'h0100, d0, 1'b0);
    rd(16'h017f, d1, 1'b0);
    rd(16'h0101, 8'h00, 1'b0);
    rd(16'h0102, 8'h00, 1'b0);
    rd(16'h0185, 8'h00, 1'b0);
    wr(16'h0181, d2);
    launch();
    wait_idle();
    rd(16'h0180, 8'h00, 1'b0);
    rd(16'h01ff, 8'h00, 1'b0);
    rd(16'h0181, d2, 1'b0);
    wr(16'h0200, d0);
    apb(1'b1, CTRL_OFS, 32'h52);
    instr_step <= 1'b1;
    @(posedge pclk);
    instr_step <= 1'b0;
    @(posedge pclk);
    apb(1'b1, CTRL_OFS, 32'ha2);
    @(posedge pclk);
    check({32'h0, prog_flag}, 33'h0);
    apb_rd(STAT_OFS, 33'h034);
    rd(16'h0200, 8'h00, 1'b0);
    repeat (4) @(posedge pclk);
    stop_test();
  end

  // A hang ends the run as a failure.
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    stop_test();
  end
endmodule : eem_access_tb
`default_nettype wire
